// ---- common/spimsp_pkg.sv ----
// spimsp_pkg: constants, types and helpers of the byte-wide serial port.
// assumes: one 100 MHz clock; registers reached through a plain strobe port.
`default_nettype none

package spimsp_pkg;

  // ************************************************************
  // register offsets (plain port, two address bits)
  // ************************************************************
  localparam logic [1:0] SPIMSP_OFS_CTRL = 2'h0;
  localparam logic [1:0] SPIMSP_OFS_STAT = 2'h1;
  localparam logic [1:0] SPIMSP_OFS_DATA = 2'h2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_XFER_IRQ_ENABLE   = 7;
  localparam int CTRL_SERIAL_ENABLE     = 6;
  localparam int CTRL_BIT_ORDER_LSB     = 5;
  localparam int CTRL_MASTER_SELECT     = 4;
  localparam int CTRL_CLOCK_IDLE_LEVEL  = 3;
  localparam int CTRL_CLOCK_SAMPLE_EDGE = 2;
  localparam int CTRL_RATE_SEL_HI       = 1;
  localparam int CTRL_RATE_SEL_LO       = 0;
  localparam int STAT_XFER_DONE_FLAG    = 7;
  localparam int STAT_WRITE_COLLISION   = 6;
  localparam int STAT_DOUBLE_RATE       = 0;

  // ************************************************************
  // reset values and transfer shape
  // ************************************************************
  localparam logic [7:0] SPIMSP_CTRL_RST = 8'h00;
  localparam logic [7:0] SPIMSP_STAT_RST = 8'h00;
  localparam logic [7:0] SPIMSP_DATA_RST = 8'h00;
  localparam logic [2:0] SPIMSP_LAST_BIT  = 3'h7;
  localparam logic [3:0] SPIMSP_LAST_EDGE = 4'hf;

  // sck divide ratio, indexed by {double_rate, rate_sel_hi, rate_sel_lo}
  localparam int unsigned SPIMSP_SCK_DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};

  typedef enum logic [1:0] {
    SPIMSP_ST_IDLE  = 2'b00,
    SPIMSP_ST_SHIFT = 2'b01,
    SPIMSP_ST_DONE  = 2'b11
  } spimsp_state_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spimsp_pin_in_t;

  // user-defined pin directions and the slave-select general output level
  typedef struct packed {
    logic sck_out;
    logic mosi_out;
    logic miso_out;
    logic ss_out;
    logic ss_level;
  } spimsp_dir_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss;
    logic ss_oe;
  } spimsp_pin_out_t;

  // bit that leaves the shift register next
  function automatic logic spimsp_head(input logic [7:0] sh, input logic lsb);
    return lsb ? sh[0] : sh[7];
  endfunction

  function automatic logic [7:0] spimsp_shift(input logic [7:0] sh, input logic b,
                                              input logic lsb);
    return lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

endpackage

`default_nettype wire

// ---- logic/spimsp_core.sv ----
// spimsp_core: byte-wide serial port, master or slave, with its three registers.
// assumes: pins already synchronous to clk_i; pad directions decided by dir_i.
//
// Chosen here: the address map and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

module spimsp_core
  import spimsp_pkg::*;
#(
  parameter int unsigned HALF_W = 7
)(
  // clock, reset, enable
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  // register port
  input  wire logic [1:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  // interrupt handshake with the cpu
  input  wire logic            gie_i,
  input  wire logic            irq_ack_i,
  output logic                 irq_o,
  // serial pins
  input  wire spimsp_pin_in_t  pin_i,
  input  wire spimsp_dir_t     dir_i,
  output spimsp_pin_out_t      pin_o
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  generate
    if (HALF_W < 7)
    begin : g_bad_width
      $error("HALF_W must hold a half period of 64 clocks");
    end
  endgenerate

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]          ctrl_r;
  logic [7:0]          sh_r;
  logic [7:0]          rxbuf_r;
  logic [7:0]          rdata_r;
  logic                done_r;
  logic                coll_r;
  logic                dbl_r;
  logic                arm_done_r;
  logic                arm_coll_r;
  spimsp_state_t       st_r;
  logic [HALF_W-1:0]   hc_r;
  logic [3:0]          ec_r;
  logic [2:0]          bits_r;
  logic                sck_ph_r;
  logic                xfer_r;
  logic                out_bit_r;
  logic                sck_prev_r;

  // ************************************************************
  // decode
  // ************************************************************
  logic                en;
  logic                mst;
  logic                clock_idle_level;
  logic                clock_sample_edge;
  logic                lsb;
  logic                wr_ctrl;
  logic                wr_stat;
  logic                wr_data;
  logic                rd_stat;
  logic                data_acc;
  logic                mode_fault;
  logic                slave_sel;
  logic [HALF_W-1:0]   half;
  logic                m_tick;
  logic                lead;
  logic                trail;
  logic                sample_ev;
  logic                setup_ev;
  logic                rx_bit;
  logic [7:0]          sh_shift;
  logic                busy;
  logic                last_sample;
  logic                done_ev;
  logic                start;

  assign en        = ctrl_r[CTRL_SERIAL_ENABLE];
  assign mst       = ctrl_r[CTRL_MASTER_SELECT];
  assign clock_idle_level      = ctrl_r[CTRL_CLOCK_IDLE_LEVEL];
  assign clock_sample_edge      = ctrl_r[CTRL_CLOCK_SAMPLE_EDGE];
  assign lsb       = ctrl_r[CTRL_BIT_ORDER_LSB];
  assign wr_ctrl   = wr_i && (addr_i == SPIMSP_OFS_CTRL);
  assign wr_stat   = wr_i && (addr_i == SPIMSP_OFS_STAT);
  assign wr_data   = wr_i && (addr_i == SPIMSP_OFS_DATA);
  assign rd_stat   = rd_i && (addr_i == SPIMSP_OFS_STAT);
  assign data_acc  = (wr_i || rd_i) && (addr_i == SPIMSP_OFS_DATA);

  assign mode_fault = en && mst && !dir_i.ss_out && !pin_i.ss_n;
  assign slave_sel  = en && !mst && !pin_i.ss_n;

  // rate bits only matter to the master clock generator
  assign half   = HALF_W'(SPIMSP_SCK_DIV[{dbl_r, ctrl_r[CTRL_RATE_SEL_HI],
                                          ctrl_r[CTRL_RATE_SEL_LO]}] / 2);
  assign m_tick = (st_r == SPIMSP_ST_SHIFT) && (hc_r == half - HALF_W'(1));

  // slave edges come from the sampled pin; each phase must span > 2 clocks
  always_comb
  begin
    if (mst)
    begin
      lead  = m_tick && !ec_r[0];
      trail = m_tick && ec_r[0];
    end
    else
    begin
      lead  = slave_sel && (sck_prev_r == clock_idle_level) && (pin_i.sck != clock_idle_level);
      trail = slave_sel && (sck_prev_r != clock_idle_level) && (pin_i.sck == clock_idle_level);
    end
  end

  assign sample_ev   = clock_sample_edge ? trail : lead;
  assign setup_ev    = clock_sample_edge ? lead : trail;
  assign rx_bit      = mst ? pin_i.miso : pin_i.mosi;
  assign sh_shift    = spimsp_shift(sh_r, rx_bit, lsb);
  assign busy        = mst ? (st_r != SPIMSP_ST_IDLE) : (xfer_r || lead);
  assign last_sample = sample_ev && (bits_r == SPIMSP_LAST_BIT) && (mst || xfer_r);
  assign done_ev     = (mst && st_r == SPIMSP_ST_DONE) || (!mst && last_sample);
  assign start       = wr_data && en && mst && !mode_fault && (st_r == SPIMSP_ST_IDLE);

  // ************************************************************
  // control and double-rate bits
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= SPIMSP_CTRL_RST;
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_r <= wdata_i;
      else if (mode_fault)
        ctrl_r[CTRL_MASTER_SELECT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dbl_r <= SPIMSP_STAT_RST[STAT_DOUBLE_RATE];
    else if (ce_i && wr_stat)
      dbl_r <= wdata_i[STAT_DOUBLE_RATE];
  end

  // ************************************************************
  // master clock generator
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r     <= SPIMSP_ST_IDLE;
      hc_r     <= '0;
      ec_r     <= 4'h0;
      sck_ph_r <= 1'b0;
    end
    else if (ce_i)
    begin
      case (st_r)
        SPIMSP_ST_IDLE:
        begin
          hc_r     <= '0;
          ec_r     <= 4'h0;
          sck_ph_r <= 1'b0;
          if (start)
            st_r <= SPIMSP_ST_SHIFT;
        end
        SPIMSP_ST_SHIFT:
        begin
          // a fault or disable aborts; sck falls back to idle level
          if (mode_fault || !en || !mst)
          begin
            st_r     <= SPIMSP_ST_IDLE;
            sck_ph_r <= 1'b0;
          end
          else if (m_tick)
          begin
            hc_r     <= '0;
            sck_ph_r <= !sck_ph_r;
            ec_r     <= ec_r + 4'h1;
            if (ec_r == SPIMSP_LAST_EDGE)
              st_r <= SPIMSP_ST_DONE;
          end
          else
            hc_r <= hc_r + HALF_W'(1);
        end
        SPIMSP_ST_DONE:
          st_r <= SPIMSP_ST_IDLE;
        default:
          st_r <= SPIMSP_ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // shift register, bit count, receive buffer
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sck_prev_r <= 1'b0;
    else if (ce_i)
      sck_prev_r <= pin_i.sck;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bits_r <= 3'h0;
      xfer_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start || (!mst && !slave_sel))
      begin
        bits_r <= 3'h0;
        xfer_r <= 1'b0;
      end
      else if (last_sample && !mst)
      begin
        bits_r <= 3'h0;
        xfer_r <= 1'b0;
      end
      else
      begin
        // every byte opens with a leading edge
        if (!mst && lead)
          xfer_r <= 1'b1;
        if (sample_ev && (mst || xfer_r || lead))
          bits_r <= bits_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sh_r <= SPIMSP_DATA_RST;
    else if (ce_i)
    begin
      if (wr_data && !busy)
        sh_r <= wdata_i;
      else if (sample_ev && (mst || xfer_r || lead))
        sh_r <= sh_shift;
    end
  end

  // output bit held apart from the shift register so a sample never moves it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_bit_r <= 1'b0;
    else if (ce_i)
    begin
      if (wr_data && !busy)
        out_bit_r <= spimsp_head(wdata_i, lsb);
      else if (setup_ev || !busy)
        out_bit_r <= spimsp_head(sh_r, lsb);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rxbuf_r <= SPIMSP_DATA_RST;
    else if (ce_i && last_sample)
      rxbuf_r <= sh_shift;
  end

  // ************************************************************
  // flags; a setting event wins over a clear in the same cycle
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_r <= SPIMSP_STAT_RST[STAT_XFER_DONE_FLAG];
      coll_r <= SPIMSP_STAT_RST[STAT_WRITE_COLLISION];
    end
    else if (ce_i)
    begin
      if (done_ev || mode_fault)
        done_r <= 1'b1;
      else if (irq_ack_i || ((arm_done_r || arm_coll_r) && data_acc))
        done_r <= 1'b0;
      if (wr_data && busy)
        coll_r <= 1'b1;
      else if (arm_coll_r && data_acc)
        coll_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      arm_done_r <= 1'b0;
      arm_coll_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rd_stat)
      begin
        arm_done_r <= done_r;
        arm_coll_r <= coll_r;
      end
      else if (data_acc)
      begin
        arm_done_r <= 1'b0;
        arm_coll_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 8'h00;
    else if (ce_i)
    begin
      rdata_r <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          SPIMSP_OFS_CTRL: rdata_r <= ctrl_r;
          SPIMSP_OFS_STAT: rdata_r <= {done_r, coll_r, 5'h00, dbl_r};
          SPIMSP_OFS_DATA: rdata_r <= rxbuf_r;
          default:         rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o   = done_r && ctrl_r[CTRL_XFER_IRQ_ENABLE] && gie_i;

  // ************************************************************
  // pins
  // ************************************************************
  always_comb
  begin
    pin_o.sck     = clock_idle_level ^ sck_ph_r;
    pin_o.sck_oe  = en && mst && dir_i.sck_out;
    pin_o.mosi    = out_bit_r;
    pin_o.mosi_oe = en && mst && dir_i.mosi_out;
    pin_o.miso    = out_bit_r;
    pin_o.miso_oe = slave_sel && dir_i.miso_out;
    pin_o.ss      = dir_i.ss_level;
    pin_o.ss_oe   = dir_i.ss_out && !(en && !mst);
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> done_r && ctrl_r[CTRL_XFER_IRQ_ENABLE] && gie_i)
    else $error("interrupt raised without flag and both enables");

  a_fault_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && mode_fault && !wr_ctrl) |=> !mst && done_r && !pin_o.sck_oe)
    else $error("mode fault did not drop to slave with flag");

  a_ss_output: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en && mst && dir_i.ss_out && !wr_ctrl) |=> mst)
    else $error("slave select output disturbed master mode");

  a_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !en) |-> !pin_o.miso_oe && !pin_o.mosi_oe ##1 (st_r != SPIMSP_ST_SHIFT))
    else $error("serial activity while disabled");

  a_desel_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !mst && pin_i.ss_n && !wr_ctrl) |=> (bits_r == 3'h0) && !xfer_r)
    else $error("slave logic not reset on deselect");

  a_miso_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_o.miso_oe |-> !mst && !pin_i.ss_n && en)
    else $error("miso driven while not selected");

  a_coll_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_data && busy && !sample_ev) |=> coll_r && (sh_r == $past(sh_r)))
    else $error("collision not flagged or byte disturbed");

  a_byte_len: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && en && mst && !mode_fault && m_tick && ec_r == SPIMSP_LAST_EDGE)
    |=> (st_r == SPIMSP_ST_DONE) && (bits_r == 3'h0) ##1 done_r)
    else $error("master byte not eight bits or flag missing");

  a_rx_buffer: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && last_sample) |=> rxbuf_r == $past(sh_shift))
    else $error("receive buffer not updated at byte end");

  a_res_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rd_stat) |=> (rdata_o[5:1] == 5'h00) && (rdata_o[7] == $past(done_r)))
    else $error("status read wrong");

  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && arm_done_r && data_acc && !done_ev && !mode_fault) |=> !done_r)
    else $error("done flag survived clear sequence");

  a_rate_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && start && dbl_r && ctrl_r[1:0] == 2'b00) |=> m_tick ##1 m_tick)
    else $error("fastest sck half period wrong");

endmodule

`default_nettype wire

// ---- test/spimsp_peer.sv ----
// spimsp_peer: behavioural serial slave standing at the far end of the port.
// assumes: sck and mosi come from the resolved pins of the bench; select comes from the DUT ss output only.
`timescale 1ns/1ps
`default_nettype none

module spimsp_peer (
  // clock for the idle pattern
  input  wire logic       clk_i,
  // serial link
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_n_i,
  output logic            miso_o,
  // mode and data
  input  wire logic       clock_idle_level_i,
  input  wire logic       clock_sample_edge_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output logic      [7:0] rx_o
);
  // ************************************************************
  // shift behaviour
  // ************************************************************
  int   idx = 8;
  logic tog = 1'b0;

  // released line toggles so a stale level never passes for data
  always @(posedge clk_i)
    tog <= ~tog;

  always @(negedge sel_n_i)
    idx = clock_sample_edge_i ? -1 : 0;

  always @(sck_i)
  begin
    if (!sel_n_i)
    begin
      if ((sck_i != clock_idle_level_i) ^ clock_sample_edge_i)
        rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      else
        idx = idx + 1;
    end
  end

  assign miso_o = (sel_n_i || idx < 0 || idx > 7) ? tog : tx_i[lsb_i ? idx : 7 - idx];
endmodule

`default_nettype wire

// ---- test/spi_master_slave_port_tb.sv ----
// spi_master_slave_port_tb: self-checking bench of the serial port.
// assumes: spimsp_peer at the far end; bench plays master for slave runs.
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_port_tb
  import spimsp_pkg::*;
;
  logic            clk = 1'b0;
  logic            rst;
  logic            ce;
  logic [1:0]      addr;
  logic [7:0]      wdata;
  logic            wr;
  logic            rd;
  logic [7:0]      rdata;
  logic            gie;
  logic            ack;
  logic            irq;
  spimsp_pin_in_t  pin_in;
  spimsp_dir_t     dir;
  spimsp_pin_out_t pin_out;
  logic            tb_sck;
  logic            tb_mosi;
  logic            tb_ss_n;
  logic            sel_n;
  logic            peer_miso;
  logic [7:0]      peer_tx;
  logic [7:0]      peer_rx;
  logic [7:0]      ctl;
  logic [31:0]     seed = 32'h8226dc3e;
  logic            sck_q;
  int              edges;
  int              bad_gap;
  int              gap;
  int              exp_h;
  int              miscompares = 0;
  int              tests_run = 0;

  spimsp_core DUT (.clk_i(clk), .rst_i(rst), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gie_i(gie), .irq_ack_i(ack), .irq_o(irq),
    .pin_i(pin_in), .dir_i(dir), .pin_o(pin_out));

  spimsp_peer PEER (.clk_i(clk), .sck_i(pin_in.sck), .mosi_i(pin_in.mosi), .sel_n_i(sel_n),
    .miso_o(peer_miso), .clock_idle_level_i(ctl[3]), .clock_sample_edge_i(ctl[2]), .lsb_i(ctl[5]), .tx_i(peer_tx),
    .rx_o(peer_rx));

  // each wire resolved from whoever enables its driver
  assign pin_in = {pin_out.sck_oe ? pin_out.sck : tb_sck, pin_out.mosi_oe ? pin_out.mosi : tb_mosi,
                   pin_out.miso_oe ? pin_out.miso : peer_miso, pin_out.ss_oe ? pin_out.ss : tb_ss_n};
  assign sel_n = pin_out.ss_oe ? pin_out.ss : 1'b1;

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // sck edge monitor: count and spacing
  // ************************************************************
  always @(posedge clk)
  begin
    sck_q <= pin_out.sck;
    gap   <= gap + 1;
    if (pin_out.sck !== sck_q)
    begin
      edges <= edges + 1;
      gap   <= 1;
      if (edges > 0 && gap != exp_h)
        bad_gap <= bad_gap + 1;
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction

  // k = {double rate, rate select}; returns clocks per sck half period
  function automatic int half_of(input logic [2:0] k);
    int base;
    base = k[2] ? 2 : 4;
    return (k[1:0] == 2'h3) ? base * 16 : base * (1 << (2 * k[1:0])) / 2;
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rdr(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 3000)
    begin
      miscompares++;
      $display("[ERR] %0t transfer never completed", $time);
      final_report();
    end
  endtask

  // master transfer with the peer selected through the general output
  task automatic mxfer(input logic [7:0] tx, input logic col);
    repeat (2) @(posedge clk);
    dir.ss_level <= 1'b0;
    edges   = 0;
    bad_gap = 0;
    wrr(SPIMSP_OFS_DATA, tx);
    if (col)
      wrr(SPIMSP_OFS_DATA, ~tx);
    wait_irq();
    dir.ss_level <= 1'b1;
  endtask

  // bench as master, mode 0 msb first, 8 clocks per bit
  task automatic sl_xfer(input logic [7:0] m, input int nb, output logic [7:0] got);
    got = 8'h00;
    @(posedge clk);
    tb_ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < nb; k++)
    begin
      tb_mosi <= m[7 - k];
      repeat (3) @(posedge clk);
      #1 got = {got[6:0], pin_in.miso};
      @(posedge clk);
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk);
      tb_sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [7:0] d;
    logic [7:0] d1;
    rst = 1'b1; ce = 1'b1; addr = 2'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    gie = 1'b1; ack = 1'b0; dir = 5'b11011; tb_sck = 1'b0; tb_mosi = 1'b0; tb_ss_n = 1'b1;
    peer_tx = 8'h00; ctl = 8'h00; exp_h = 1; edges = 0; bad_gap = 0; gap = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wrr(2'h3, 8'hff);
    wrr(SPIMSP_OFS_STAT, 8'hff);
    for (int a = 0; a < 4; a++)
    begin
      rdr(a[1:0], d);
      chk(d, (a == 1) ? 8'h01 : 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      peer_tx = seed[15:8];
      ctl = {2'b11, seed[16], 1'b1, seed[18:17], i[1:0]};
      exp_h = half_of(i[2:0]);
      wrr(SPIMSP_OFS_STAT, {7'h00, i[2]});
      wrr(SPIMSP_OFS_CTRL, ctl);
      mxfer(seed[7:0], 1'b0);
      chk(edges[7:0], 8'h10);
      chk(bad_gap[7:0], 8'h00);
      chk({7'h00, pin_out.sck}, {7'h00, ctl[3]});
      chk(peer_rx, seed[7:0]);
      rdr(SPIMSP_OFS_STAT, d);
      chk(d, {1'b1, 6'h00, i[2]});
      rdr(SPIMSP_OFS_DATA, d);
      chk(d, peer_tx);
      chk({7'h00, irq}, 8'h00);
    end
    ctl = 8'hd1;
    wrr(SPIMSP_OFS_STAT, 8'h00);
    wrr(SPIMSP_OFS_CTRL, ctl);
    seed = xs(seed);
    peer_tx = seed[15:8];
    mxfer(seed[7:0], 1'b1);
    chk(peer_rx, seed[7:0]);
    @(posedge clk);
    gie <= 1'b0;
    @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    gie <= 1'b1;
    wrr(SPIMSP_OFS_CTRL, 8'h50);
    #1 chk({7'h00, irq}, 8'h00);
    wrr(SPIMSP_OFS_CTRL, 8'hd0);
    #1 chk({7'h00, irq}, 8'h01);
    rdr(SPIMSP_OFS_STAT, d);
    chk(d, 8'hc0);
    rdr(SPIMSP_OFS_DATA, d);
    chk(d, peer_tx);
    rdr(SPIMSP_OFS_STAT, d);
    chk(d, 8'h00);
    @(posedge clk);
    dir <= 5'b11001;
    tb_ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    chk({6'h00, pin_out.sck_oe, pin_out.mosi_oe}, 8'h00);
    rdr(SPIMSP_OFS_CTRL, d);
    chk(d, 8'hc0);
    @(posedge clk);
    tb_ss_n <= 1'b1;
    repeat (20) @(posedge clk);
    rdr(SPIMSP_OFS_CTRL, d);
    chk(d, 8'hc0);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    dir <= 5'b11011;
    wrr(SPIMSP_OFS_CTRL, 8'h10);
    edges = 0;
    wrr(SPIMSP_OFS_DATA, 8'h5a);
    repeat (100) @(posedge clk);
    chk(edges[7:0], 8'h00);
    rdr(SPIMSP_OFS_STAT, d);
    chk(d, 8'h00);
    wrr(SPIMSP_OFS_CTRL, 8'h40);
    @(posedge clk);
    dir <= 5'b00101;
    @(posedge clk);
    #1 chk({7'h00, pin_out.miso_oe}, 8'h00);
    seed = xs(seed);
    d1 = seed[7:0];
    wrr(SPIMSP_OFS_DATA, d1);
    sl_xfer(seed[15:8], 3, d);
    @(posedge clk);
    tb_ss_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({7'h00, pin_out.miso_oe}, 8'h00);
    wrr(SPIMSP_OFS_DATA, d1);
    sl_xfer(seed[23:16], 8, d);
    chk(d, d1);
    #1 chk({7'h00, pin_out.miso_oe}, 8'h01);
    rdr(SPIMSP_OFS_STAT, d);
    chk(d, 8'h80);
    rdr(SPIMSP_OFS_DATA, d);
    chk(d, seed[23:16]);
    final_report();
  end
endmodule

`default_nettype wire
